// *** dcp_ddr2_pins.sv ***
// Purpose: Device end of the DDR2 command, mask and data pins
// Assumes: ck_in is the rising crossing of the differential clock
// Notes:   Decoded commands are handed to clk_in by a toggle
`timescale 1ns/1ps
`include "dcp_params.svh"

module dcp_ddr2_pins import dcp_pkg::*; (
    input  wire logic        clk_in,          // Core clock
    input  wire logic        arst_n_in,       // Async reset, low active
    input  wire logic        ck_in,           // Link clock, true side
    input  wire logic        cke_in,          // Clock enable
    input  wire logic        cs_n_in,         // Chip select, low active
    input  wire logic        ras_n_in,        // Row strobe, low active
    input  wire logic        cas_n_in,        // Column strobe, low active
    input  wire logic        we_n_in,         // Write enable, low active
    input  wire logic [1:0]  ba_in,           // Bank select
    input  wire logic [12:0] addr_in,         // Address
    input  wire logic [15:0] dq_in,           // Data pins, input side
    input  wire logic [1:0]  dm_in,           // {upper, lower} data mask
    output logic      [15:0] dq_out,          // Data pins, output side
    output logic             dq_oe_out,       // Data pins driven
    output logic      [1:0]  dqs_out,         // {upper, lower} strobe
    output logic             dqs_oe_out,      // Strobes driven
    output logic             cmd_valid_out,   // One cycle per command
    output dcp_cmd_t         cmd_code_out,    // Command decoded
    output logic      [1:0]  cmd_bank_out,    // Bank of command
    output logic      [12:0] cmd_addr_out,    // Address of command
    output logic             link_awake_out   // Clock enable seen high
);

    logic      lrst1_n_ff;                    // Link reset sync stage 1
    logic      lrst2_n_ff;                    // Link reset sync stage 2
    logic      crst1_n_ff;                    // Core reset sync stage 1
    logic      crst2_n_ff;                    // Core reset sync stage 2
    dcp_link_t l_ff;                          // Link state
    dcp_link_t nxt_l;                         // Next link state
    logic [15:0] fall_dq_ff;                  // Falling write beat
    logic [1:0]  fall_dm_ff;                  // Falling write mask
    dcp_core_t c_ff;                          // Core state
    dcp_core_t nxt_c;                         // Next core state
    dcp_cmd_t  pin_cmd;                       // Decode of the pins

    // Release the reset into the link domain
    always_ff @(posedge ck_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lrst1_n_ff <= 1'b0;
            lrst2_n_ff <= 1'b0;
        end else begin
            lrst1_n_ff <= 1'b1;
            lrst2_n_ff <= lrst1_n_ff;
        end
    end

    // Release the reset into the core domain
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crst1_n_ff <= 1'b0;
            crst2_n_ff <= 1'b0;
        end else begin
            crst1_n_ff <= 1'b1;
            crst2_n_ff <= crst1_n_ff;
        end
    end

    // Decode the strobes; a deselected cycle is masked
    always_comb begin
        if (cs_n_in) begin
            pin_cmd = DCP_DESEL;
        end else begin
            case ({ras_n_in, cas_n_in, we_n_in})
                `DCP_CODE_MRS: pin_cmd = DCP_MRS;
                `DCP_CODE_REF: pin_cmd = DCP_REF;
                `DCP_CODE_PRE: pin_cmd = DCP_PRE;
                `DCP_CODE_ACT: pin_cmd = DCP_ACT;
                `DCP_CODE_WR:  pin_cmd = DCP_WR;
                `DCP_CODE_RD:  pin_cmd = DCP_RD;
                default:       pin_cmd = DCP_NOP;
            endcase
        end
    end

    // Second write beat and mask, caught on the falling crossing
    always_ff @(negedge ck_in or negedge lrst2_n_ff) begin
        if (!lrst2_n_ff) begin
            fall_dq_ff <= `DCP_RST_WORD;
            fall_dm_ff <= 2'h3;
        end else begin
            fall_dq_ff <= dq_in;
            fall_dm_ff <= dm_in;
        end
    end

    // Link sequencer: command capture, bank state, bursts
    always_comb begin
        logic [4:0] idx;                                          // Array word of first beat
        nxt_l     = l_ff;
        idx       = {l_ff.ibank, l_ff.icol, (l_ff.cnt == `DCP_WR_PAIR1), 1'b0};
        nxt_l.cke = cke_in;
        if (cke_in) begin
            nxt_l.rd_oe = 1'b0;
            nxt_l.wdq   = dq_in;
            nxt_l.wdm   = dm_in;
            case (l_ff.st)
                DCP_LS_IDLE: begin
                    // Command, bank and address pins are taken on the rising crossing
                    if (pin_cmd != DCP_DESEL && pin_cmd != DCP_NOP) begin
                        nxt_l.cmd  = pin_cmd;
                        nxt_l.bank = ba_in;
                        nxt_l.addr = addr_in;
                        nxt_l.tog  = ~l_ff.tog;
                    end
                    nxt_l.ibank = ba_in;
                    nxt_l.icol  = addr_in[`DCP_COL_BIT];
                    nxt_l.cnt   = 2'h0;
                    case (pin_cmd)
                        DCP_ACT: nxt_l.open[ba_in] = 1'b1;
                        DCP_PRE: begin
                            if (addr_in[`DCP_AP_BIT]) begin
                                nxt_l.open = `DCP_RST_OPEN;
                            end else begin
                                nxt_l.open[ba_in] = 1'b0;
                            end
                        end
                        DCP_WR: begin
                            if (l_ff.open[ba_in]) begin
                                nxt_l.st = DCP_LS_WR;
                            end
                        end
                        DCP_RD: begin
                            if (l_ff.open[ba_in]) begin
                                nxt_l.st = DCP_LS_RD;
                            end
                        end
                        default: ;
                    endcase
                end
                DCP_LS_WR: begin
                    // Pair of beats lands one clock after it arrives
                    nxt_l.cnt = l_ff.cnt + 2'h1;
                    if (l_ff.cnt != 2'h0) begin
                        for (int b = 0; b < 2; b++) begin
                            if (!l_ff.wdm[b]) begin
                                nxt_l.mem[idx][b*8 +: 8] = l_ff.wdq[b*8 +: 8];
                            end
                            if (!fall_dm_ff[b]) begin
                                nxt_l.mem[idx | 5'h01][b*8 +: 8] = fall_dq_ff[b*8 +: 8];
                            end
                        end
                    end
                    if (l_ff.cnt == `DCP_WR_PAIR1) begin
                        nxt_l.st = DCP_LS_IDLE;
                    end
                end
                DCP_LS_RD: begin
                    // Two beats per clock once the latency has run
                    nxt_l.cnt = l_ff.cnt + 2'h1;
                    if (l_ff.cnt >= `DCP_WR_PAIR0 && l_ff.cnt < `DCP_RD_END) begin
                        idx         = {l_ff.ibank, l_ff.icol, (l_ff.cnt == `DCP_RD_LAT), 1'b0};
                        nxt_l.rd_a  = l_ff.mem[idx];
                        nxt_l.rd_b  = l_ff.mem[idx | 5'h01];
                        nxt_l.rd_oe = 1'b1;
                    end
                    if (l_ff.cnt == `DCP_RD_END) begin
                        nxt_l.st = DCP_LS_IDLE;
                    end
                end
                default: nxt_l.st = DCP_LS_IDLE;
            endcase
        end
    end

    // Link state register
    always_ff @(posedge ck_in or negedge lrst2_n_ff) begin
        if (!lrst2_n_ff) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // Read drive: high half carries first beat, low half second
    always_comb begin
        dq_out     = ck_in ? l_ff.rd_a : l_ff.rd_b;
        dq_oe_out  = l_ff.rd_oe;
        dqs_out    = {2{ck_in & l_ff.rd_oe}};
        dqs_oe_out = l_ff.rd_oe;
    end

    // Core side: toggle and level synchronisers, then a copy
    always_comb begin
        nxt_c       = c_ff;
        nxt_c.tsy1  = l_ff.tog;
        nxt_c.tsy2  = c_ff.tsy1;
        nxt_c.tlast = c_ff.tsy2;
        nxt_c.asy1  = l_ff.cke;
        nxt_c.asy2  = c_ff.asy1;
        nxt_c.valid = c_ff.tsy2 ^ c_ff.tlast;
        // Command words stay put for a whole link clock, so they are settled
        if (c_ff.tsy2 ^ c_ff.tlast) begin
            nxt_c.cmd  = l_ff.cmd;
            nxt_c.bank = l_ff.bank;
            nxt_c.addr = l_ff.addr;
        end
    end

    // Core state register
    always_ff @(posedge clk_in or negedge crst2_n_ff) begin
        if (!crst2_n_ff) begin
            c_ff <= '0;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // Core outputs
    always_comb begin
        cmd_valid_out  = c_ff.valid;
        cmd_code_out   = c_ff.cmd;
        cmd_bank_out   = c_ff.bank;
        cmd_addr_out   = c_ff.addr;
        link_awake_out = c_ff.asy2;
    end

endmodule : dcp_ddr2_pins

// *** dcp_params.svh ***
// Purpose: Constants for the DDR2 command pin interface
// Assumes: Included by the design file and the bench
// Notes:   Command codes are {ras_n, cas_n, we_n} as sampled
//
// Overview of operation
// - Chip select high masks every command
// - Command decoded from RAS, CAS, WE, CS
// - Masked write bytes never reach the array
// - Data masks sampled on both link clock edges
// - Command and address inputs captured on rising true clock
// - Read data launched on both clock crossings
// - Clock enable registered high runs internal clocking
// - Bank select steers activate, read, write, precharge
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// Command strobe codes
`define DCP_CODE_MRS  3'h0
`define DCP_CODE_REF  3'h1
`define DCP_CODE_PRE  3'h2
`define DCP_CODE_ACT  3'h3
`define DCP_CODE_WR   3'h4
`define DCP_CODE_RD   3'h5

// Field positions
`define DCP_AP_BIT    10
`define DCP_COL_BIT   2

// Read latency in link clocks, last read count
`define DCP_RD_LAT    2'h2
`define DCP_RD_END    2'h3
// Write burst pair counts
`define DCP_WR_PAIR0  2'h1
`define DCP_WR_PAIR1  2'h2

// Reset values
`define DCP_RST_WORD  16'h0000
`define DCP_RST_OPEN  4'h0

`endif

// *** dcp_pkg.sv ***
// Purpose: Types for the DDR2 command pin interface
// Assumes: Used by dcp_ddr2_pins
// Notes:   Holds types only; numbers live in dcp_params.svh
package dcp_pkg;

    // Decoded command
    typedef enum logic [2:0] {
        DCP_DESEL, DCP_NOP, DCP_ACT, DCP_RD, DCP_WR, DCP_PRE, DCP_REF, DCP_MRS
    } dcp_cmd_t;

    // Link side sequencer states
    typedef enum logic [1:0] {
        DCP_LS_IDLE, DCP_LS_WR, DCP_LS_RD
    } dcp_lst_t;

    // Link domain state
    typedef struct packed {
        logic [31:0][15:0] mem;     // Storage array, {bank, col2, pair, beat}
        dcp_cmd_t          cmd;     // Last accepted command
        logic [1:0]        bank;    // Its bank
        logic [12:0]       addr;    // Its address
        logic              tog;     // Flips per accepted command
        logic              cke;     // Registered clock enable
        dcp_lst_t          st;      // Burst sequencer
        logic [1:0]        cnt;     // Burst cycle counter
        logic [1:0]        ibank;   // Bank of running burst
        logic              icol;    // Column half of running burst
        logic [3:0]        open;    // Activated banks
        logic [15:0]       rd_a;    // Read beat for clock high
        logic [15:0]       rd_b;    // Read beat for clock low
        logic              rd_oe;   // Read drive window
        logic [15:0]       wdq;     // Rising write beat
        logic [1:0]        wdm;     // Rising write mask
    } dcp_link_t;

    // Core domain state
    typedef struct packed {
        logic       tsy1;           // Toggle sync first stage
        logic       tsy2;           // Toggle sync second stage
        logic       tlast;          // Toggle seen before
        logic       asy1;           // Awake sync first stage
        logic       asy2;           // Awake sync second stage
        logic       valid;          // Command strobe
        dcp_cmd_t   cmd;            // Command copy
        logic [1:0] bank;           // Bank copy
        logic [12:0] addr;          // Address copy
    } dcp_core_t;

endpackage : dcp_pkg

// *** dcp_ddr2_pins_monitor.sv ***
// Purpose: Concurrent checks on the DDR2 command pin ports
// Assumes: Bound to dcp_ddr2_pins
// Notes:   Link clock checks use ck_in, the rest clk_in
`timescale 1ns/1ps
module dcp_ddr2_pins_monitor import dcp_pkg::*; (
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic        ck_in,
    input wire logic        cke_in,
    input wire logic        dq_oe_out,
    input wire logic [1:0]  dqs_out,
    input wire logic        dqs_oe_out,
    input wire logic        cmd_valid_out,
    input dcp_cmd_t         cmd_code_out,
    input wire logic [1:0]  cmd_bank_out,
    input wire logic [12:0] cmd_addr_out,
    input wire logic        link_awake_out
);
    valid_pulse_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmd_valid_out |=> !cmd_valid_out) else $error("command strobe too long");
    code_legal_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmd_valid_out |-> !(cmd_code_out inside {DCP_DESEL, DCP_NOP})) else $error("idle code strobed");
    cmd_hold_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !cmd_valid_out |-> $stable({cmd_code_out, cmd_bank_out, cmd_addr_out})) else $error("command moved");
    oe_pair_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        dq_oe_out == dqs_oe_out) else $error("data and strobe enables differ");
    strobe_idle_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !dqs_oe_out |-> dqs_out == 2'h0) else $error("strobe not parked");
    strobe_follow_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        dqs_oe_out |-> dqs_out == {2{ck_in}}) else $error("strobe not on link clock");
    read_span_a : assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(dq_oe_out) |-> dq_oe_out [*8] ##[1:4] !dq_oe_out) else $error("read window length");
    awake_hi_a : assert property (@(posedge ck_in) disable iff (!arst_n_in)
        cke_in [*6] |-> link_awake_out) else $error("awake missing");
    awake_lo_a : assert property (@(posedge ck_in) disable iff (!arst_n_in)
        (!cke_in) [*4] |-> !link_awake_out) else $error("awake stuck");
endmodule : dcp_ddr2_pins_monitor

// *** dcp_ctl_model.sv ***
// Purpose: Controller side model driving link pins
// Assumes: Commands change on falling link edge
// Notes:   Released data lines show inverted last beat
`timescale 1ns/1ps
module dcp_ctl_model (
    output logic        ck_out,
    output logic        cke_out,
    output logic        cs_n_out,
    output logic [2:0]  cmd_out,
    output logic [1:0]  ba_out,
    output logic [12:0] addr_out,
    output logic [15:0] dq_out,
    output logic [1:0]  dm_out
);
    // Free running link clock, phase offset from core clock
    initial begin
        ck_out = 1'b0;
        #7;
        forever #62.5 ck_out = ~ck_out;
    end
    initial begin
        cke_out = 1'b1; cs_n_out = 1'b1; cmd_out = 3'h7; ba_out = 2'h0;
        addr_out = 13'h0000; dq_out = 16'hA5A5; dm_out = 2'h3;
    end
    // One command cycle, then deselect with scrambled lines
    task automatic issue(input logic cs_n, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
        @(negedge ck_out);
        cs_n_out <= cs_n; cmd_out <= c; ba_out <= b; addr_out <= a;
        @(negedge ck_out);
        cs_n_out <= 1'b1; cmd_out <= 3'h7; ba_out <= ~b; addr_out <= ~a;
    endtask : issue
    // Four beats with masks, one per link edge
    task automatic beats(input logic [63:0] d, input logic [7:0] m);
        for (int i = 0; i < 4; i++) begin
            #31; dq_out <= d[16*i+:16]; dm_out <= m[2*i+:2];
            @(ck_out);
        end
        #31; dq_out <= ~d[63:48]; dm_out <= 2'h3;
    endtask : beats
endmodule : dcp_ctl_model

// *** ddr2_command_pin_interface_test.sv ***
// Purpose: Self-checking bench for the DDR2 command pin interface
// Assumes: Controller model drives link pins
// Notes:   Expected results queued, watchers compare
`timescale 1ns/1ps
`include "dcp_params.svh"
module ddr2_command_pin_interface_test import dcp_pkg::*;;
    logic        clk_in, arst_n_in, ck, cke, cs_n, dq_oe, dqs_oe, c_val, awake;
    logic [2:0]  cmd;
    logic [1:0]  ba, dm, dqs, c_bank;
    logic [12:0] addr, c_addr;
    logic [15:0] p_dq, dq_o, dq_w;
    dcp_cmd_t    c_code;
    logic [17:0] cq[$], rq[$];
    logic [15:0] mem[32];
    logic [31:0] seed = 32'h0000FDAE;
    int          errors, n_tests;
    assign dq_w = dq_oe ? dq_o : p_dq;
    dcp_ctl_model dcp_ctl_model_inst (.ck_out(ck), .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd),
        .ba_out(ba), .addr_out(addr), .dq_out(p_dq), .dm_out(dm));
    dcp_ddr2_pins dcp_ddr2_pins_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .ck_in(ck), .cke_in(cke),
        .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr),
        .dq_in(dq_w), .dm_in(dm), .dq_out(dq_o), .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(dqs_oe),
        .cmd_valid_out(c_val), .cmd_code_out(c_code), .cmd_bank_out(c_bank), .cmd_addr_out(c_addr),
        .link_awake_out(awake));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic send(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
        dcp_cmd_t k;
        k = (c == `DCP_CODE_ACT) ? DCP_ACT : (c == `DCP_CODE_WR) ? DCP_WR : (c == `DCP_CODE_RD) ? DCP_RD :
            (c == `DCP_CODE_PRE) ? DCP_PRE : (c == `DCP_CODE_REF) ? DCP_REF : DCP_MRS;
        cq.push_back({k, b, a});
        dcp_ctl_model_inst.issue(1'b0, c, b, a);
    endtask : send
    task automatic wr(input logic [1:0] b, input logic h, input logic [7:0] m);
        logic [63:0] d;
        d = {xs(), xs()};
        send(`DCP_CODE_WR, b, {10'h000, h, 2'h0});
        dcp_ctl_model_inst.beats(d, m);
        for (int i = 0; i < 4; i++) begin
            if (!m[2*i]) mem[{b, h, i[1:0]}][7:0] = d[16*i+:8];
            if (!m[2*i+1]) mem[{b, h, i[1:0]}][15:8] = d[16*i+8+:8];
        end
    endtask : wr
    task automatic rd(input logic [1:0] b, input logic h);
        for (int i = 0; i < 4; i++) rq.push_back({2'h0, mem[{b, h, i[1:0]}]});
        send(`DCP_CODE_RD, b, {10'h000, h, 2'h0});
        repeat (4) @(posedge ck);
    endtask : rd
    // Command watcher: every strobe must match the oldest note
    always @(negedge clk_in) begin
        if (c_val === 1'b1) begin
            if (cq.size() == 0) check("cmd_extra", 18'h00000, 18'h3FFFF);
            else check("cmd", cq.pop_front(), {c_code, c_bank, c_addr});
        end
    end
    // Read watcher: one beat per link clock phase
    always @(posedge ck) begin
        #31;
        if (dq_oe === 1'b1 && rq.size() < 2) begin
            check("rd_extra", 18'h00000, 18'h3FFFF);
        end else if (dq_oe === 1'b1) begin
            check("rd_hi", rq.pop_front(), {2'h0, dq_o});
            @(negedge ck);
            #31;
            check("rd_lo", rq.pop_front(), {2'h0, dq_o});
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        #30000;
        errors++;
        tally_and_finish();
    end
    initial begin
        arst_n_in = 1'b0; errors = 0; n_tests = 0;
        foreach (mem[i]) mem[i] = 16'h0000;
        repeat (2) @(posedge clk_in);
        repeat (3) @(posedge ck);
        @(posedge clk_in) arst_n_in <= 1'b1;
        repeat (3) @(posedge ck);
        dcp_ctl_model_inst.issue(1'b1, `DCP_CODE_ACT, 2'h1, 13'h0000);
        dcp_ctl_model_inst.cke_out <= 1'b0;
        dcp_ctl_model_inst.issue(1'b0, `DCP_CODE_ACT, 2'h1, 13'h0000);
        repeat (2) @(posedge ck);
        check("awake_lo", 18'h00000, {17'h00000, awake});
        dcp_ctl_model_inst.cke_out <= 1'b1;
        repeat (6) @(posedge ck);
        check("awake_hi", 18'h00001, {17'h00000, awake});
        send(`DCP_CODE_ACT, 2'h1, 13'(xs()));
        wr(2'h1, 1'b1, 8'(xs()));
        send(`DCP_CODE_ACT, 2'h2, 13'(xs()));
        wr(2'h2, 1'b0, 8'h00);
        rd(2'h1, 1'b1);
        rd(2'h2, 1'b0);
        rd(2'h1, 1'b0);
        dcp_ctl_model_inst.issue(1'b0, 3'h7, 2'h1, 13'h0000);
        send(`DCP_CODE_PRE, 2'h2, 13'h0000);
        send(`DCP_CODE_RD, 2'h2, 13'h0000);
        repeat (4) @(posedge ck);
        rd(2'h1, 1'b1);
        send(`DCP_CODE_PRE, 2'h0, 13'h0400);
        send(`DCP_CODE_RD, 2'h1, 13'h0004);
        repeat (4) @(posedge ck);
        send(`DCP_CODE_REF, 2'h0, 13'h0000);
        send(`DCP_CODE_MRS, 2'h3, 13'(xs()));
        repeat (6) @(posedge ck);
        check("queues", 18'h00000, 18'(cq.size() + rq.size()));
        tally_and_finish();
    end
endmodule : ddr2_command_pin_interface_test
bind dcp_ddr2_pins dcp_ddr2_pins_monitor dcp_ddr2_pins_monitor_inst (.clk_in, .arst_n_in, .ck_in, .cke_in,
    .dq_oe_out, .dqs_out, .dqs_oe_out, .cmd_valid_out, .cmd_code_out, .cmd_bank_out, .cmd_addr_out,
    .link_awake_out);
